// >>> dv/smbms_slave.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// Slave on the wire; lines it releases go to the pull-up level
module smbms_slave #(
   parameter logic [6:0] ADDR = 7'h2a,
   parameter logic [7:0] RD   = 8'hb5
) (
   input  wire logic       scl,
   input  wire logic       sda,
   output logic            pull,
   output logic [7:0]      got
);
   int         cnt   = 0;
   logic       act   = 0;
   logic       first = 0;
   logic       rd    = 0;
   logic       mnack = 0;
   logic [7:0] sh    = 8'h00;
   initial pull = 0;
   initial got = 8'h00;
   always @(negedge sda) if (scl) begin
      act = 1;
      first = 1;
      rd = 0;
      // A NACK from the last transfer must not silence the next one
      mnack = 0;
      cnt = -1;
      pull = 0;
   end
   always @(posedge sda) if (scl) begin
      act = 0;
      pull = 0;
   end
   always @(posedge scl) if (act) begin
      if (cnt < 8) sh = {sh[6:0], sda};
      else if (rd) mnack = sda;
   end
   always @(negedge scl) if (act) begin
      cnt = cnt + 1;
      if (cnt == 8) begin
         if (!rd) got = sh;
         // Wrong address is left unanswered, which is how NACK is provoked
         pull = !rd && (!first || sh[7:1] == ADDR);
      end else if (cnt == 9) begin
         cnt = 0;
         if (first) rd = sh[0];
         first = 0;
         pull = rd && !mnack && !RD[7];
      end else pull = rd && !mnack && !RD[7-cnt];
   end
endmodule : smbms_slave
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin failures++; \
   $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module tb;
   import smbms_pkg::*;
   logic           clk = 0;
   logic           rst = 1;
   smbms_avm_req_t avm_req = '0;
   smbms_avm_rsp_t avm_rsp;
   smbms_pin_in_t  pin_in;
   smbms_pin_out_t pin_out;
   logic           pull;
   logic [7:0]     sl_got;
   logic [31:0]    q;
   int             failures = 0;
   int             n_compared = 0;
   int             cyc = 0;
   wire            scl = !pin_out.scl_oe;
   wire            sda = !pin_out.sda_oe && !pull;
   assign pin_in = '{scl_i: scl, sda_i: sda};
   always #10 clk = ~clk;
   smbms_top i_dut (.clk(clk), .rst(rst), .avm_req(avm_req), .avm_rsp(avm_rsp),
      .pin_in(pin_in), .pin_out(pin_out));
   smbms_slave i_slave (.scl(scl), .sda(sda), .pull(pull), .got(sl_got));
   // =====
   // Bus access, called just after a rising edge
   task automatic acc(input logic w, input logic [1:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      avm_req <= '{read: !w, write: w, address: a, writedata: d};
      do @(posedge clk); while (avm_rsp.waitrequest !== 1'b0);
      r = avm_rsp.readdata;
      avm_req <= '0;
      @(posedge clk);
   endtask : acc
   // Answer one event, then wait for the next one (or for idle)
   task automatic step(input logic dw, input logic [7:0] d, input logic [5:0] c,
                       input logic [3:0] v, input logic k);
      logic [31:0] r;
      if (dw) acc(1, OFF_DATA, {24'h0, d}, r);
      acc(1, OFF_CTRL, {26'h0, c}, r);
      if (v == ST_IDLE) begin
         do acc(0, OFF_STATUS, 0, r); while (r[SB_BUSY] !== 1'b0);
      end else begin
         do acc(0, OFF_CTRL, 0, r); while (r[CB_SI] !== 1'b1);
         `CHK("scl_held", 1'b1, pin_out.scl_oe)
         acc(0, OFF_STATUS, 0, r);
         if (v != ST_START) `CHK("ack", k, r[SB_ACK])
      end
      `CHK("status", {2'b00, v}, r[5:0])
   endtask : step
   task automatic rdd(input logic [7:0] e);
      logic [31:0] r;
      acc(0, OFF_DATA, 0, r);
      `CHK("rx_data", {24'h0, e}, r)
   endtask : rdd
   task automatic complete_run;
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         complete_run();
      end
   end
   // =====
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      acc(0, OFF_CTRL, 0, q);
      `CHK("ctrl_rst", 32'h10, q)
      acc(0, OFF_STATUS, 0, q);
      `CHK("status_rst", 32'h0, q)
      acc(0, OFF_DIV, 0, q);
      `CHK("div_rst", 32'h7d, q)
      acc(1, OFF_DIV, 32'h4, q);
      step(0, 8'h00, 6'h31, ST_START, 0);
      step(1, 8'h26, 6'h30, ST_TX, 0);
      step(0, 8'h00, 6'h31, ST_START, 0);
      step(1, 8'h54, 6'h30, ST_TX, 1);
      step(1, 8'hc3, 6'h30, ST_TX, 1);
      `CHK("wire_byte", 8'hc3, sl_got)
      step(0, 8'h00, 6'h33, ST_START, 0);
      step(1, 8'h54, 6'h30, ST_TX, 1);
      step(0, 8'h00, 6'h32, ST_IDLE, 0);
      $display("Test transmit done");
      step(0, 8'h00, 6'h31, ST_START, 0);
      step(1, 8'h55, 6'h30, ST_TX, 1);
      step(0, 8'h00, 6'h34, ST_RX, 1);
      step(0, 8'h00, 6'h34, ST_RX, 1);
      acc(0, OFF_STATUS, 0, q);
      `CHK("rx_full", 1'b1, q[SB_RXV])
      rdd(8'hb5);
      step(0, 8'h00, 6'h30, ST_RX, 0);
      rdd(8'hb5);
      rdd(8'hb5);
      acc(0, OFF_STATUS, 0, q);
      `CHK("rx_empty", 1'b0, q[SB_RXV])
      step(0, 8'h00, 6'h33, ST_START, 0);
      step(1, 8'h55, 6'h30, ST_TX, 1);
      step(0, 8'h00, 6'h34, ST_RX, 1);
      step(0, 8'h00, 6'h31, ST_START, 0);
      step(1, 8'h55, 6'h30, ST_TX, 1);
      step(0, 8'h00, 6'h34, ST_RX, 1);
      step(1, 8'h77, 6'h30, ST_TX, 0);
      rdd(8'hb5);
      rdd(8'hb5);
      step(0, 8'h00, 6'h31, ST_START, 0);
      step(1, 8'h26, 6'h30, ST_TX, 0);
      step(0, 8'h00, 6'h32, ST_IDLE, 0);
      $display("Test receive done");
      complete_run();
   end
endmodule : tb
`default_nettype wire

// >>> logic/smbms_fifo2.sv
`timescale 1ns/1ps
`default_nettype none
module smbms_fifo2 #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [PW:0]      cnt_q;
   logic             push;
   logic             pop;

   initial begin
      if (DEPTH < 2 || (1 << PW) != DEPTH) $error("smbms_fifo2: DEPTH must be a power of two >= 2");
   end

   assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + PW'(1);
         if (pop)  rd_q <= rd_q + PW'(1);
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : smbms_fifo2
`default_nettype wire

// >>> logic/smbms_pkg.sv
`default_nettype none
package smbms_pkg;
   // ==========================================================
   // Timing
   localparam int          CLK_NS      = 20;
   localparam int          QUARTER_NS  = 2500;
   localparam int          QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
   localparam int          DIV_W       = 16;
   localparam int          BYTE_BITS   = 8;

   // ==========================================================
   // Register word indices
   localparam logic [1:0]  OFF_CTRL    = 2'h0;
   localparam logic [1:0]  OFF_STATUS  = 2'h1;
   localparam logic [1:0]  OFF_DATA    = 2'h2;
   localparam logic [1:0]  OFF_DIV     = 2'h3;

   // Control bits
   localparam int          CB_START    = 0;
   localparam int          CB_STOP     = 1;
   localparam int          CB_ACK      = 2;
   localparam int          CB_SI       = 3;
   localparam int          CB_HWACK    = 4;
   localparam int          CB_EN       = 5;

   // Status bits
   localparam int          SB_VEC      = 0;
   localparam int          SB_ACK_REQ  = 4;
   localparam int          SB_ARB      = 5;
   localparam int          SB_ACK      = 6;
   localparam int          SB_BUSY     = 7;
   localparam int          SB_RXV      = 8;

   // Status vector codes
   localparam logic [3:0]  ST_IDLE     = 4'h0;
   localparam logic [3:0]  ST_START    = 4'he;
   localparam logic [3:0]  ST_TX       = 4'hc;
   localparam logic [3:0]  ST_RX       = 4'h8;

   // Reset values
   localparam logic [4:0]  CTRL_RST    = 5'h08;
   localparam logic [DIV_W-1:0] DIV_RST = DIV_W'(QUARTER_CYC);

   // ==========================================================
   // Types
   typedef struct packed {
      logic        en;
      logic        hw_ack_generation_enable;
      logic        ack;
      logic        stop_request;
      logic        start_request;
   } smbms_ctrl_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [1:0]  address;
      logic [31:0] writedata;
   } smbms_avm_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } smbms_avm_rsp_t;

   typedef struct packed {
      logic        scl_i;
      logic        sda_i;
   } smbms_pin_in_t;

   typedef struct packed {
      logic        scl_o;
      logic        scl_oe;
      logic        sda_o;
      logic        sda_oe;
   } smbms_pin_out_t;

   typedef enum logic [4:0] {
      E_IDLE  = 5'b00001,
      E_START = 5'b00010,
      E_BIT   = 5'b00100,
      E_STOP  = 5'b01000,
      E_HOLD  = 5'b10000
   } smbms_eng_t;
endpackage : smbms_pkg
`default_nettype wire

// >>> logic/smbms_sync.sv
`timescale 1ns/1ps
`default_nettype none
module smbms_sync #(
   parameter int             WIDTH   = 2,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   initial begin
      if (WIDTH < 1) $error("smbms_sync: WIDTH must be at least 1");
   end

   // First stage is read only by the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q   <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : smbms_sync
`default_nettype wire

// >>> logic/smbms_top.sv
`timescale 1ns/1ps
`default_nettype none
module smbms_top #(
   parameter int FIFO_DEPTH = 2
) (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire smbms_pkg::smbms_avm_req_t avm_req,
   output smbms_pkg::smbms_avm_rsp_t     avm_rsp,
   input  wire smbms_pkg::smbms_pin_in_t  pin_in,
   output smbms_pkg::smbms_pin_out_t     pin_out
);
   import smbms_pkg::*;

   initial begin
      if (FIFO_DEPTH < 2) $error("smbms_top: FIFO_DEPTH must be at least 2");
   end

   // ==========================================================
   // Declarations
   smbms_ctrl_t            ctrl_q;
   smbms_eng_t             state_q;
   logic                   si_q;
   logic [3:0]             status_q;
   logic                   ack_q;
   logic [BYTE_BITS-1:0]   data_q;
   logic                   tx_pend_q;
   logic [DIV_W-1:0]       div_q;
   logic [DIV_W-1:0]       cnt_q;
   logic                   tick_q;
   logic [1:0]             phase_q;
   logic [3:0]             bitc_q;
   logic [BYTE_BITS-1:0]   shift_q;
   logic                   rx_mode_q;
   logic                   scl_low_q;
   logic                   sda_low_q;
   logic                   wait_q;
   logic [31:0]            rdata_q;
   logic [31:0]            rd_d;
   logic                   scl_s;
   logic                   sda_s;
   logic                   acc_start;
   logic                   acc_done;
   logic                   wr_ctrl;
   logic                   wr_data;
   logic                   wr_div;
   logic                   pop;
   logic                   step;
   logic                   start_done;
   logic                   stop_done;
   logic                   byte_done;
   logic                   ack_sample;
   logic                   go;
   logic                   launch_tx;
   logic                   launch_rx;
   logic                   rx_ok;
   logic                   buf_in_ready;
   logic                   buf_out_valid;
   logic [BYTE_BITS-1:0]   buf_out_data;
   logic                   bit_drive;

   // ==========================================================
   // Pin synchronisers
   smbms_sync #(
      .WIDTH   (2),
      .RST_VAL (2'h3)
   ) u_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in ({pin_in.scl_i, pin_in.sda_i}),
      .sync_out ({scl_s, sda_s})
   );

   // Open-drain: output value is always low, the enable pulls the wire
   assign pin_out = '{scl_o: 1'b0, scl_oe: scl_low_q, sda_o: 1'b0, sda_oe: sda_low_q};

   // ==========================================================
   // Avalon-MM slave, one wait cycle per access
   assign acc_start = (avm_req.read || avm_req.write) && wait_q;
   assign acc_done  = (avm_req.read || avm_req.write) && !wait_q;
   assign wr_ctrl   = acc_done && avm_req.write && (avm_req.address == OFF_CTRL);
   assign wr_data   = acc_done && avm_req.write && (avm_req.address == OFF_DATA);
   assign wr_div    = acc_done && avm_req.write && (avm_req.address == OFF_DIV);
   assign pop       = acc_done && avm_req.read && (avm_req.address == OFF_DATA);
   assign avm_rsp   = '{readdata: rdata_q, waitrequest: wait_q};

   always_comb begin
      rd_d = '0;
      unique case (avm_req.address)
         OFF_CTRL: begin
            rd_d[CB_START] = ctrl_q.start_request;
            rd_d[CB_STOP]  = ctrl_q.stop_request;
            rd_d[CB_ACK]   = ctrl_q.ack;
            rd_d[CB_SI]    = si_q;
            rd_d[CB_HWACK] = ctrl_q.hw_ack_generation_enable;
            rd_d[CB_EN]    = ctrl_q.en;
         end
         OFF_STATUS: begin
            rd_d[SB_VEC +: 4] = status_q;
            rd_d[SB_ACK_REQ]  = 1'b0;
            rd_d[SB_ARB]      = 1'b0;
            rd_d[SB_ACK]      = ack_q;
            rd_d[SB_BUSY]     = (state_q != E_IDLE);
            rd_d[SB_RXV]      = buf_out_valid;
         end
         OFF_DATA: rd_d[BYTE_BITS-1:0] = buf_out_valid ? buf_out_data : data_q;
         OFF_DIV:  rd_d[DIV_W-1:0]     = div_q;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wait_q  <= 1'b1;
         rdata_q <= '0;
      end else if (!wait_q) begin
         wait_q  <= 1'b1;
      end else if (acc_start) begin
         wait_q  <= 1'b0;
         rdata_q <= avm_req.read ? rd_d : '0;
      end
   end

   // ==========================================================
   // Control register; software set wins over the hardware clear
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= smbms_ctrl_t'(CTRL_RST);
      end else if (wr_ctrl) begin
         ctrl_q.start_request            <= avm_req.writedata[CB_START];
         ctrl_q.stop_request             <= avm_req.writedata[CB_STOP];
         ctrl_q.ack                      <= avm_req.writedata[CB_ACK];
         ctrl_q.hw_ack_generation_enable <= avm_req.writedata[CB_HWACK];
         ctrl_q.en                       <= avm_req.writedata[CB_EN];
      end else begin
         if (start_done) ctrl_q.start_request <= 1'b0;
         if (stop_done)  ctrl_q.stop_request  <= 1'b0;
      end
   end

   // Event flag: hardware set wins; writing 1 has no effect
   always_ff @(posedge clk) begin
      if (rst) begin
         si_q <= 1'b0;
      end else if (start_done || byte_done) begin
         si_q <= 1'b1;
      end else if (wr_ctrl && !avm_req.writedata[CB_SI]) begin
         si_q <= 1'b0;
      end
   end

   // Transmit byte and its pending mark
   always_ff @(posedge clk) begin
      if (rst) begin
         data_q    <= '0;
         tx_pend_q <= 1'b0;
      end else if (wr_data) begin
         data_q    <= avm_req.writedata[BYTE_BITS-1:0];
         tx_pend_q <= 1'b1;
      end else if (launch_tx) begin
         tx_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         div_q <= DIV_RST;
      end else if (wr_div) begin
         div_q <= avm_req.writedata[DIV_W-1:0];
      end
   end

   // ==========================================================
   // Quarter-bit tick
   always_ff @(posedge clk) begin
      if (rst || !ctrl_q.en) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else if (cnt_q == '0) begin
         cnt_q  <= div_q;
         tick_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q - DIV_W'(1);
         tick_q <= 1'b0;
      end
   end

   // Phase 2 waits for SCL high, which lets a slave stretch the clock
   assign step       = tick_q && !(phase_q == 2'd2 && !scl_s);
   assign start_done = (state_q == E_START) && step && (phase_q == 2'd3);
   assign stop_done  = (state_q == E_STOP) && step && (phase_q == 2'd3);
   assign byte_done  = (state_q == E_BIT) && step && (phase_q == 2'd3) && (bitc_q == 4'd8) &&
                       (!rx_mode_q || buf_in_ready);
   assign ack_sample = (state_q == E_BIT) && step && (phase_q == 2'd2) && (bitc_q == 4'd8);
   assign go         = (state_q == E_HOLD) && !si_q;
   assign rx_ok      = (status_q == ST_RX) || ((status_q == ST_TX) && ack_q);
   assign launch_tx  = go && !ctrl_q.stop_request && !ctrl_q.start_request && tx_pend_q;
   assign launch_rx  = go && !ctrl_q.stop_request && !ctrl_q.start_request && !tx_pend_q && rx_ok;
   // Ack slot: receiver pulls low only with automatic ACK on and ack set
   assign bit_drive  = (bitc_q != 4'd8) ? (!rx_mode_q && !shift_q[BYTE_BITS-1]) :
                       (rx_mode_q && ctrl_q.hw_ack_generation_enable && ctrl_q.ack);

   // ==========================================================
   // Bus sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q   <= E_IDLE;
         phase_q   <= 2'd0;
         bitc_q    <= 4'd0;
         shift_q   <= '0;
         rx_mode_q <= 1'b0;
         scl_low_q <= 1'b0;
         sda_low_q <= 1'b0;
      end else begin
         unique case (state_q)
            E_IDLE: begin
               if (ctrl_q.en && ctrl_q.start_request) begin
                  state_q <= E_START;
                  phase_q <= 2'd0;
               end
            end
            E_START: begin
               if (step) begin
                  phase_q <= phase_q + 2'd1;
                  unique case (phase_q)
                     2'd0: sda_low_q <= 1'b0;
                     2'd1: scl_low_q <= 1'b0;
                     2'd2: sda_low_q <= 1'b1;
                     2'd3: begin
                        scl_low_q <= 1'b1;
                        state_q   <= E_HOLD;
                     end
                  endcase
               end
            end
            E_BIT: begin
               if (step) begin
                  unique case (phase_q)
                     2'd0: begin
                        sda_low_q <= bit_drive;
                        phase_q   <= 2'd1;
                     end
                     2'd1: begin
                        scl_low_q <= 1'b0;
                        phase_q   <= 2'd2;
                     end
                     2'd2: begin
                        if (bitc_q != 4'd8) shift_q <= {shift_q[BYTE_BITS-2:0], sda_s};
                        phase_q <= 2'd3;
                     end
                     2'd3: begin
                        scl_low_q <= 1'b1;
                        if (bitc_q != 4'd8) begin
                           bitc_q  <= bitc_q + 4'd1;
                           phase_q <= 2'd0;
                        end else if (byte_done) begin
                           // A full receive buffer holds SCL low here; SDA keeps the
                           // ack slot level, as moving it with the falling SCL would race
                           phase_q   <= 2'd0;
                           state_q   <= E_HOLD;
                        end
                     end
                  endcase
               end
            end
            E_STOP: begin
               if (step) begin
                  phase_q <= phase_q + 2'd1;
                  unique case (phase_q)
                     2'd0: sda_low_q <= 1'b1;
                     2'd1: scl_low_q <= 1'b0;
                     2'd2: sda_low_q <= 1'b0;
                     2'd3: state_q <= ctrl_q.start_request ? E_START : E_IDLE;
                  endcase
               end
            end
            E_HOLD: begin
               // SCL stays low until software clears the flag
               if (go) begin
                  phase_q <= 2'd0;
                  bitc_q  <= 4'd0;
                  if (ctrl_q.stop_request) begin
                     state_q <= E_STOP;
                  end else if (ctrl_q.start_request) begin
                     state_q <= E_START;
                  end else if (launch_tx) begin
                     state_q   <= E_BIT;
                     rx_mode_q <= 1'b0;
                     shift_q   <= data_q;
                  end else if (launch_rx) begin
                     state_q   <= E_BIT;
                     rx_mode_q <= 1'b1;
                     shift_q   <= '0;
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Status vector and acknowledge bit
   always_ff @(posedge clk) begin
      if (rst) begin
         status_q <= ST_IDLE;
      end else if (start_done) begin
         status_q <= ST_START;
      end else if (byte_done) begin
         status_q <= rx_mode_q ? ST_RX : ST_TX;
      end else if (stop_done && !ctrl_q.start_request) begin
         status_q <= ST_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else if (ack_sample) begin
         ack_q <= rx_mode_q ? (ctrl_q.hw_ack_generation_enable && ctrl_q.ack) : !sda_s;
      end
   end

   // ==========================================================
   // Receive buffer; a full buffer stalls the sequencer
   smbms_fifo2 #(
      .WIDTH (BYTE_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_rxbuf (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (byte_done && rx_mode_q),
      .in_ready  (buf_in_ready),
      .in_data   (shift_q),
      .out_valid (buf_out_valid),
      .out_ready (pop),
      .out_data  (buf_out_data)
   );

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   flags_zero_a: assert property ((avm_req.read && wait_q && avm_req.address == OFF_STATUS)
      |=> (avm_rsp.readdata[SB_ACK_REQ] == 1'b0) && (avm_rsp.readdata[SB_ARB] == 1'b0))
      else $error("status flags not zero");
   start_code_a: assert property (start_done |=> si_q && (status_q == ST_START)
      && (state_q == E_HOLD)) else $error("start event not reported as 1110");
   hold_stall_a: assert property ((state_q == E_HOLD) && si_q |=> (state_q == E_HOLD)
      && scl_low_q) else $error("bus not stalled while flag set");
   tx_launch_a: assert property (launch_tx |=> (state_q == E_BIT) && !rx_mode_q
      && !tx_pend_q) else $error("pending byte not transmitted");
   rx_launch_a: assert property (launch_rx |=> (state_q == E_BIT) && rx_mode_q)
      else $error("receive not started");
   stop_launch_a: assert property (go && ctrl_q.stop_request |=> (state_q == E_STOP))
      else $error("stop request not served");
   stop_start_a: assert property (stop_done && ctrl_q.start_request |=> (state_q == E_START))
      else $error("start after stop missing");
   rx_code_a: assert property (byte_done && rx_mode_q |=> si_q && (status_q == ST_RX))
      else $error("received byte not reported as 1000");
   ack_drive_a: assert property ((state_q == E_BIT) && rx_mode_q && (bitc_q == 4'd8)
      && step && (phase_q == 2'd0) |=> sda_low_q == (ctrl_q.hw_ack_generation_enable
      && ctrl_q.ack)) else $error("ack slot driven wrongly");
   bus_wait_a: assert property (acc_start |=> !wait_q ##1 wait_q)
      else $error("bus answer not one cycle");

   rx_byte_c: cover property (byte_done && rx_mode_q);
   stop_start_c: cover property (stop_done && ctrl_q.start_request);
   restart_c: cover property (go && !ctrl_q.stop_request && ctrl_q.start_request);
   rx_stall_c: cover property ((state_q == E_BIT) && rx_mode_q && !buf_in_ready);
endmodule : smbms_top
`default_nettype wire
